// ### bipt_pkg.sv
`default_nettype none

package bipt_pkg;

    // ******************************************************
    // Sizes
    // ******************************************************
    localparam int unsigned NLINES = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IRQ_W  = 3;

    // ******************************************************
    // Register byte offsets
    // ******************************************************
    localparam logic [ADDR_W-1:0] ADDR_BIT_IO_DIRECTION_AND_LEVEL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_BIT_IO_COMMAND_PATTERN     = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_AUXILIARY_FLAGS_AND_POWER  = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS                 = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR                  = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE                 = 8'h14;

    // ******************************************************
    // Field positions
    // ******************************************************
    localparam int unsigned LINE_DIRECTION_LSB = 8;
    localparam int unsigned LEVEL_LSB          = 0;
    localparam int unsigned SELECT_LSB         = 8;
    localparam int unsigned PATTERN_BITS_LSB   = 0;
    localparam int unsigned STANDBY_ENABLE_BIT = 15;
    localparam int unsigned RAM_LOW_PLACE_BIT  = 14;
    localparam int unsigned FLAG_ALL_TRUE      = 0;
    localparam int unsigned FLAG_ALL_FALSE     = 1;
    localparam int unsigned FLAG_SOME_TRUE     = 2;
    localparam int unsigned FLAG_SOME_FALSE    = 3;
    localparam int unsigned IRQ_EVAL_DONE      = 0;
    localparam int unsigned IRQ_ALL_TRUE       = 1;
    localparam int unsigned IRQ_SOME_FALSE     = 2;

    // ******************************************************
    // Reset values
    // ******************************************************
    localparam logic [NLINES-1:0] RST_LINE_DIRECTION = 8'h00;
    localparam logic [NLINES-1:0] RST_LINE_OUT       = 8'h00;
    localparam logic [15:0]       RST_COMMAND        = 16'h0000;
    localparam logic [3:0]        RST_FLAGS          = 4'h0;
    localparam logic [IRQ_W-1:0]  RST_IRQ            = 3'h0;

    // ******************************************************
    // Whole state of the unit
    // ******************************************************
    typedef struct packed {
        logic [NLINES-1:0] sync_a;
        logic [NLINES-1:0] sync_b;
        logic [NLINES-1:0] dir;
        logic [NLINES-1:0] outv;
        logic [15:0]       cmd;
        logic [3:0]        flags;
        logic              standby;
        logic              low_place;
        logic [IRQ_W-1:0]  ists;
        logic [IRQ_W-1:0]  ien;
        logic              irq;
        logic [DATA_W-1:0] rdata;
        logic              ready;
        logic              slverr;
    } bipt_state_s;

endpackage

`default_nettype wire

// ### bipt_line.sv
`timescale 1ns/10ps
`default_nettype none

// One general-purpose line: command action and test result
module bipt_line (
    // Line setup
    input  wire logic dir_in,
    input  wire logic sel_in,
    input  wire logic pat_in,
    // Line state
    input  wire logic cur_in,
    input  wire logic level_in,
    // Results
    output logic      nxt_out,
    output logic      match_out,
    output logic      miss_out
);

    logic tested;

    // Output lines: clear, set, keep or toggle
    assign nxt_out = dir_in ? (sel_in ? (pat_in ? ~cur_in : cur_in) : pat_in)
                            : cur_in; // [R3] [R4]

    // Input lines take part only when selected
    assign tested    = ~dir_in & sel_in;             // [R5]
    assign match_out = tested & (level_in == pat_in); // [R6]
    assign miss_out  = tested & (level_in != pat_in); // [R6]

endmodule // bipt_line

`default_nettype wire

// ### bipt_unit.sv
//Behaviour
//[R1] Direction byte: one makes line output
//[R2] Level byte reads every line's present level
//[R3] Output, select zero: pattern clears or sets
//[R4] Output, select one: keep or toggle
//[R5] Input, select zero: line not tested
//[R6] Input, select one: compare level with pattern
//[R7] Flag 0: every tested line matches
//[R8] Flag 1: no tested line matches
//[R9] Flag 2: some tested line matches
//[R10] Flag 3: some tested line mismatches
//[R11] Standby bit 15, placement 14, 13-8 reserved
//[R12] Reset: all inputs; flags on command write
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none

module bipt_unit (
    // Clock, reset, enable
    input  wire logic                          clk_in,
    input  wire logic                          sys_rst_in,
    input  wire logic                          ce_in,
    // APB slave
    input  wire logic                          apb_psel_in,
    input  wire logic                          apb_penable_in,
    input  wire logic                          apb_pwrite_in,
    input  wire logic [bipt_pkg::ADDR_W-1:0]   apb_paddr_in,
    input  wire logic [bipt_pkg::DATA_W-1:0]   apb_pwdata_in,
    output logic      [bipt_pkg::DATA_W-1:0]   apb_prdata_out,
    output logic                               apb_pready_out,
    output logic                               apb_pslverr_out,
    // General-purpose lines
    input  wire logic [bipt_pkg::NLINES-1:0]   user_line_in,
    output logic      [bipt_pkg::NLINES-1:0]   user_line_out,
    output logic      [bipt_pkg::NLINES-1:0]   user_line_oe_out,
    // Power and placement controls
    output logic                               standby_enable_out,
    output logic                               ram_low_placement_out,
    // Interrupt
    output logic                               irq_out
);
    import bipt_pkg::*;

    // ******************************************************
    // State and decode
    // ******************************************************
    bipt_state_s       st_r;
    bipt_state_s       st_nxt;
    logic              setup;
    logic              acc;
    logic              wr;
    logic              hit;
    logic [NLINES-1:0] line_nxt;
    logic [NLINES-1:0] match;
    logic [NLINES-1:0] miss;
    logic [3:0]        flags_new;
    logic [IRQ_W-1:0]  ev;
    logic [IRQ_W-1:0]  clr;

    // Setup phase is answered at once; access closes on the next edge
    assign setup = apb_psel_in & ~apb_penable_in & ~st_r.ready;
    assign acc   = apb_psel_in & apb_penable_in & st_r.ready;
    assign wr    = acc & apb_pwrite_in;

    // Address decode, unmapped offsets answer with an error
    always_comb begin
        unique case (apb_paddr_in)
            ADDR_BIT_IO_DIRECTION_AND_LEVEL,
            ADDR_BIT_IO_COMMAND_PATTERN,
            ADDR_AUXILIARY_FLAGS_AND_POWER,
            ADDR_IRQ_STATUS,
            ADDR_IRQ_CLEAR,
            ADDR_IRQ_ENABLE: hit = 1'b1;
            default:         hit = 1'b0;
        endcase
    end

    // ******************************************************
    // Per-line command evaluation
    // ******************************************************
    // Driven from the write data so the action lands with the write
    genvar gi;
    generate
        for (gi = 0; gi < NLINES; gi++) begin : g_line
            bipt_line u_line (
                .dir_in    (st_r.dir[gi]),
                .sel_in    (apb_pwdata_in[SELECT_LSB + gi]),
                .pat_in    (apb_pwdata_in[PATTERN_BITS_LSB + gi]),
                .cur_in    (st_r.outv[gi]),
                .level_in  (st_r.sync_b[gi]),
                .nxt_out   (line_nxt[gi]),
                .match_out (match[gi]),
                .miss_out  (miss[gi])
            );
        end
    endgenerate

    // Summary flags; with nothing tested both "all" flags read one
    always_comb begin
        flags_new                  = 4'h0;
        flags_new[FLAG_ALL_TRUE]   = ~|miss;  // [R7]
        flags_new[FLAG_ALL_FALSE]  = ~|match; // [R8]
        flags_new[FLAG_SOME_TRUE]  = |match;  // [R9]
        flags_new[FLAG_SOME_FALSE] = |miss;   // [R10]
    end

    // ******************************************************
    // Next state
    // ******************************************************
    always_comb begin
        st_nxt        = st_r;
        ev            = RST_IRQ;
        clr           = RST_IRQ;
        // Two-stage synchroniser on the pins
        st_nxt.sync_a = user_line_in;
        st_nxt.sync_b = st_r.sync_a;
        st_nxt.ready  = 1'b0;
        st_nxt.slverr = 1'b0;

        // Read data is captured in setup and held through access
        if (setup) begin
            st_nxt.ready  = 1'b1;
            st_nxt.slverr = ~hit;
            st_nxt.rdata  = '0;
            unique case (apb_paddr_in)
                ADDR_BIT_IO_DIRECTION_AND_LEVEL: begin
                    st_nxt.rdata[LINE_DIRECTION_LSB +: NLINES] = st_r.dir;
                    st_nxt.rdata[LEVEL_LSB +: NLINES] = st_r.sync_b; // [R2]
                end
                ADDR_BIT_IO_COMMAND_PATTERN: begin
                    st_nxt.rdata[15:0] = st_r.cmd;
                end
                ADDR_AUXILIARY_FLAGS_AND_POWER: begin
                    // Bits 13-8 reserved, BMU flags absent: read zero
                    st_nxt.rdata[STANDBY_ENABLE_BIT] = st_r.standby;  // [R11]
                    st_nxt.rdata[RAM_LOW_PLACE_BIT]  = st_r.low_place; // [R11]
                    st_nxt.rdata[3:0]                = st_r.flags;
                end
                ADDR_IRQ_STATUS: begin
                    st_nxt.rdata[IRQ_W-1:0] = st_r.ists;
                end
                ADDR_IRQ_ENABLE: begin
                    st_nxt.rdata[IRQ_W-1:0] = st_r.ien;
                end
                default: begin
                    st_nxt.rdata = '0;
                end
            endcase
        end

        // Writes take effect only on the closing access edge
        if (wr) begin
            unique case (apb_paddr_in)
                ADDR_BIT_IO_DIRECTION_AND_LEVEL: begin
                    // Level byte is read-only; writes there are dropped
                    st_nxt.dir = apb_pwdata_in[LINE_DIRECTION_LSB +: NLINES]; // [R1]
                end
                ADDR_BIT_IO_COMMAND_PATTERN: begin
                    st_nxt.cmd   = apb_pwdata_in[15:0];
                    st_nxt.outv  = line_nxt;  // [R3] [R4]
                    st_nxt.flags = flags_new; // [R12]
                    ev[IRQ_EVAL_DONE]  = 1'b1;
                    ev[IRQ_ALL_TRUE]   = flags_new[FLAG_ALL_TRUE];
                    ev[IRQ_SOME_FALSE] = flags_new[FLAG_SOME_FALSE];
                end
                ADDR_AUXILIARY_FLAGS_AND_POWER: begin
                    // Test flags are owned by hardware, only the top bits store
                    st_nxt.standby   = apb_pwdata_in[STANDBY_ENABLE_BIT];
                    st_nxt.low_place = apb_pwdata_in[RAM_LOW_PLACE_BIT];
                end
                ADDR_IRQ_CLEAR: begin
                    clr = apb_pwdata_in[IRQ_W-1:0];
                end
                ADDR_IRQ_ENABLE: begin
                    st_nxt.ien = apb_pwdata_in[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Sticky status; a new event beats a clear in the same cycle
        st_nxt.ists = (st_r.ists & ~clr) | ev;
        st_nxt.irq  = |(st_nxt.ists & st_nxt.ien);
    end

    // ******************************************************
    // State register
    // ******************************************************
    // Clock enable freezes everything, the synchroniser included
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_r           <= '0;
            st_r.dir       <= RST_LINE_DIRECTION; // [R12]
            st_r.outv      <= RST_LINE_OUT;
            st_r.cmd       <= RST_COMMAND;
            st_r.flags     <= RST_FLAGS;
            st_r.ists      <= RST_IRQ;
            st_r.ien       <= RST_IRQ;
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state flops
    assign apb_prdata_out        = st_r.rdata;
    assign apb_pready_out        = st_r.ready;
    assign apb_pslverr_out       = st_r.slverr;
    assign user_line_out         = st_r.outv;
    assign user_line_oe_out      = st_r.dir; // [R1]
    assign standby_enable_out    = st_r.standby;
    assign ram_low_placement_out = st_r.low_place;
    assign irq_out               = st_r.irq;

    // ******************************************************
    // Checks
    // ******************************************************
    logic wr_dir;
    logic wr_cmd;
    logic rd_lvl;
    logic rd_aux;
    logic [NLINES-1:0] out_sel0;
    logic [NLINES-1:0] out_tgl;
    logic wr_clr;
    logic wr_sts;
    logic bad_setup;

    assign wr_dir   = ce_in & wr & (apb_paddr_in == ADDR_BIT_IO_DIRECTION_AND_LEVEL);
    assign wr_cmd   = ce_in & wr & (apb_paddr_in == ADDR_BIT_IO_COMMAND_PATTERN);
    assign rd_lvl   = ce_in & setup & ~apb_pwrite_in
                    & (apb_paddr_in == ADDR_BIT_IO_DIRECTION_AND_LEVEL);
    assign rd_aux   = ce_in & setup & ~apb_pwrite_in
                    & (apb_paddr_in == ADDR_AUXILIARY_FLAGS_AND_POWER);
    assign out_sel0 = st_r.dir & ~apb_pwdata_in[SELECT_LSB +: NLINES];
    assign out_tgl  = st_r.dir & apb_pwdata_in[SELECT_LSB +: NLINES]
                    & apb_pwdata_in[PATTERN_BITS_LSB +: NLINES];

    // Interrupt register writes and refused setups, for the bus checks
    assign wr_clr    = ce_in & wr & (apb_paddr_in == ADDR_IRQ_CLEAR);
    assign wr_sts    = ce_in & wr & (apb_paddr_in == ADDR_IRQ_STATUS);
    assign bad_setup = ce_in & setup & ~hit;

    AST_DIR_DRIVES: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R1]
        wr_dir |=> user_line_oe_out == $past(apb_pwdata_in[15:8]))
        else $error("direction write not on enables");

    AST_LEVEL_READ: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R2]
        rd_lvl |=> apb_pready_out && apb_prdata_out[7:0] == $past(st_r.sync_b))
        else $error("level byte does not show the lines");

    AST_SET_CLEAR: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R3]
        wr_cmd |=> ((user_line_out ^ $past(apb_pwdata_in[7:0])) & $past(out_sel0)) == 8'h00)
        else $error("clear or set not applied");

    AST_TOGGLE: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R4]
        wr_cmd |=> ((user_line_out ^ ~$past(user_line_out)) & $past(out_tgl)) == 8'h00)
        else $error("toggle not applied");

    AST_NO_TEST: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R5]
        ((match | miss) & (st_r.dir | ~apb_pwdata_in[15:8])) == 8'h00)
        else $error("untested line took part");

    AST_COMPARE: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R6]
        (match & (st_r.sync_b ^ apb_pwdata_in[7:0])) == 8'h00
        && (miss & ~(st_r.sync_b ^ apb_pwdata_in[7:0])) == 8'h00)
        else $error("level compare wrong");

    AST_ALL_TRUE: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R7]
        wr_cmd |=> st_r.flags[0] == ($past(miss) == 8'h00))
        else $error("all-true flag wrong");

    AST_ALL_FALSE: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R8]
        wr_cmd |=> st_r.flags[1] == ($past(match) == 8'h00))
        else $error("all-false flag wrong");

    AST_SOME_TRUE: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R9]
        wr_cmd |=> st_r.flags[2] == ($past(match) != 8'h00))
        else $error("some-true flag wrong");

    AST_SOME_FALSE: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R10]
        wr_cmd |=> st_r.flags[3] == ($past(miss) != 8'h00))
        else $error("some-false flag wrong");

    AST_AUX_LAYOUT: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R11]
        rd_aux |=> apb_prdata_out[13:4] == 10'h000
        && apb_prdata_out[15] == standby_enable_out
        && apb_prdata_out[14] == ram_low_placement_out)
        else $error("auxiliary flag layout wrong");

    AST_RESET_INPUTS: assert property (@(posedge clk_in) // [R12]
        sys_rst_in |=> user_line_oe_out == 8'h00 && irq_out == 1'b0)
        else $error("lines not inputs after reset");

    AST_FLAGS_HOLD: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R12]
        !wr_cmd |=> st_r.flags == $past(st_r.flags))
        else $error("flags moved without a command");

    AST_IRQ_STICKY: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_cmd ##1 ce_in) |=> st_r.ists[IRQ_EVAL_DONE])
        else $error("evaluation event lost");

    AST_PREADY_ONE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        apb_pready_out && ce_in |=> !apb_pready_out)
        else $error("pready held over two cycles");

    AST_DIR_HOLD: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R1]
        !wr_dir |=> user_line_oe_out == $past(user_line_oe_out))
        else $error("direction moved without a write");

    // Input lines keep their stored value, ready for a turn to output
    AST_INPUT_KEEP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_cmd |=> ((user_line_out ^ $past(user_line_out)) & ~$past(st_r.dir)) == 8'h00)
        else $error("input line value changed by a command");

    AST_DIR_KEEPS_OUT: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R1]
        wr_dir |=> user_line_out == $past(user_line_out))
        else $error("direction write moved output values");

    // Zero wait states: every taken setup is answered on the next edge
    AST_SETUP_ANSWER: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        setup && ce_in |=> apb_pready_out)
        else $error("setup not answered");

    AST_UNMAPPED: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        bad_setup |=> apb_pslverr_out && apb_prdata_out == 32'h0000_0000)
        else $error("unmapped access not refused");

    AST_STATUS_RO: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_sts |=> st_r.ists == $past(st_r.ists))
        else $error("status register took a write");

    AST_IRQ_CLEAR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_clr |=> (st_r.ists & $past(apb_pwdata_in[IRQ_W-1:0])) == '0)
        else $error("status bit not cleared");

    AST_IRQ_LEVEL: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        irq_out == |(st_r.ists & st_r.ien))
        else $error("interrupt level wrong");

    // A low enable freezes every flop, so a stalled bus resumes intact
    AST_CE_FREEZE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !ce_in |=> st_r == $past(st_r))
        else $error("state moved with enable low");

endmodule // bipt_unit

`default_nettype wire

// ### bipt_pins.sv
`timescale 1ns/10ps
`default_nettype none

// Board circuitry on the eight lines: drives each line the unit leaves as input
module bipt_pins (
    // Unit side
    input  wire logic [bipt_pkg::NLINES-1:0] line_out_in,
    input  wire logic [bipt_pkg::NLINES-1:0] line_oe_in,
    // Board side
    input  wire logic [bipt_pkg::NLINES-1:0] ext_drive_in,
    output logic      [bipt_pkg::NLINES-1:0] pin_level_out
);
    import bipt_pkg::*;

    // Unit wins where it drives, so an output line reads back its own value
    assign pin_level_out = (line_oe_in & line_out_in) | (~line_oe_in & ext_drive_in);
endmodule // bipt_pins

`default_nettype wire

// ### bit_io_port_with_test_flags_bench.sv
`timescale 1ns/10ps
`default_nettype none

module bit_io_port_with_test_flags_bench;
    import bipt_pkg::*;

    // ******************************
    // Stimulus and observed signals
    // ******************************
    logic              clk_in     = 1'b0;
    logic              sys_rst_in = 1'b1;
    logic              ce         = 1'b1;
    logic              psel       = 1'b0;
    logic              penable    = 1'b0;
    logic              pwrite     = 1'b0;
    logic [ADDR_W-1:0] paddr      = 8'h00;
    logic [DATA_W-1:0] pwdata     = 32'h0;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic [7:0]        ext_lvl    = 8'hC3;
    logic [7:0]        pin_lvl;
    logic [7:0]        line_out;
    logic [7:0]        line_oe;
    logic              standby;
    logic              low_place;
    logic              irq;
    logic [7:0]        m_out      = 8'h00;
    logic [1:0]        m_aux      = 2'h0;
    logic [DATA_W-1:0] rd;
    logic              err;
    int                n_fail     = 0;
    int                n_tests    = 0;
    int                cycles     = 0;
    int                seed       = 20;

    bipt_unit u_bipt_unit (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce),
        .apb_psel_in(psel), .apb_penable_in(penable), .apb_pwrite_in(pwrite),
        .apb_paddr_in(paddr), .apb_pwdata_in(pwdata), .apb_prdata_out(prdata),
        .apb_pready_out(pready), .apb_pslverr_out(pslverr), .user_line_in(pin_lvl),
        .user_line_out(line_out), .user_line_oe_out(line_oe),
        .standby_enable_out(standby), .ram_low_placement_out(low_place), .irq_out(irq));

    bipt_pins u_bipt_pins (.line_out_in(line_out), .line_oe_in(line_oe),
        .ext_drive_in(ext_lvl), .pin_level_out(pin_lvl));

    // Clock and a hang guard sized well above the expected run
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_fail = n_fail + 1;
            final_report();
        end
    end

    // ******************************
    // Checking and bus tasks
    // ******************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            n_fail = n_fail + 1;
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1 && n < 40) begin
            @(posedge clk_in);
            n = n + 1;
        end
        chk("pready", 32'h1, {31'h0, pready});
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask

    // Pattern-test flags: {some false, some true, all false, all true}
    function automatic logic [3:0] exp_flags(input logic [7:0] dir, lvl, sel, pat);
        logic [7:0] hit;
        logic [7:0] miss;
        hit  = sel & ~dir & ~(lvl ^ pat);
        miss = sel & ~dir & (lvl ^ pat);
        return {miss != 8'h0, hit != 8'h0, hit == 8'h0, miss == 8'h0};
    endfunction

    // Output lines: clear/set with select low, keep/toggle with select high
    function automatic logic [7:0] exp_out(input logic [7:0] dir, sel, pat, cur);
        return (dir & ~sel & pat) | (dir & sel & (cur ^ pat)) | (~dir & cur);
    endfunction

    // Set directions and board levels, read levels, issue one command
    task automatic cmd_step(input logic [7:0] dir, ext, sel, pat);
        logic [7:0] lvl;
        logic [3:0] f;
        apb(1'b1, ADDR_BIT_IO_DIRECTION_AND_LEVEL, {16'h0, dir, 8'hA5});
        ext_lvl <= ext;
        repeat (4) @(posedge clk_in);
        lvl = (dir & m_out) | (~dir & ext);
        rdchk("dir_level", ADDR_BIT_IO_DIRECTION_AND_LEVEL, {16'h0, dir, lvl});
        f     = exp_flags(dir, lvl, sel, pat);
        m_out = exp_out(dir, sel, pat, m_out);
        apb(1'b1, ADDR_BIT_IO_COMMAND_PATTERN, {16'h0, sel, pat});
        @(negedge clk_in);
        chk("line_out", {24'h0, m_out}, {24'h0, line_out});
        chk("line_oe", {24'h0, dir}, {24'h0, line_oe});
        rdchk("aux", ADDR_AUXILIARY_FLAGS_AND_POWER,
              {16'h0, m_aux, 10'h0, f});
        rdchk("command", ADDR_BIT_IO_COMMAND_PATTERN, {16'h0, sel, pat});
    endtask

    task automatic final_report();
        $display("Checks made %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ******************************
    // Main sequence
    // ******************************
    initial begin
        repeat (20) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        chk("oe_reset", 32'h0, {24'h0, line_oe});
        chk("irq_reset", 32'h0, {31'h0, irq});
        rdchk("aux_reset", ADDR_AUXILIARY_FLAGS_AND_POWER, 32'h0);
        rdchk("lvl_reset", ADDR_BIT_IO_DIRECTION_AND_LEVEL, 32'h0000_00C3);
        $display("test reset done");
        // Corner cases: untested, all match, none match, set/clear, keep/toggle
        cmd_step(8'h00, 8'hA5, 8'h00, 8'hFF);
        cmd_step(8'h00, 8'hA5, 8'hFF, 8'hA5);
        cmd_step(8'h00, 8'hA5, 8'hFF, 8'h5A);
        cmd_step(8'hFF, 8'h00, 8'h00, 8'h3C);
        cmd_step(8'hFF, 8'h00, 8'hF0, 8'hCC);
        cmd_step(8'h0F, 8'h5A, 8'hFF, 8'h33);
        $display("test corners done");
        for (int i = 0; i < 40; i++) begin
            cmd_step($random(seed), $random(seed),
                     $random(seed), $random(seed));
        end
        $display("test random done");
        // Standby and placement bits, flags not writable
        apb(1'b1, ADDR_AUXILIARY_FLAGS_AND_POWER, 32'hFFFF_FFFF);
        m_aux = 2'b11;
        @(negedge clk_in);
        chk("standby", 32'h3, {30'h0, standby, low_place});
        cmd_step(8'h00, 8'h0F, 8'h0F, 8'h0F);
        apb(1'b1, ADDR_AUXILIARY_FLAGS_AND_POWER, 32'h0000_4000);
        m_aux = 2'b01;
        @(negedge clk_in);
        chk("placement", 32'h1, {30'h0, standby, low_place});
        $display("test aux done");
        // Unmapped address and write-only clear register
        apb(1'b0, 8'h18, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        chk("unmapped_data", 32'h0, rd);
        rdchk("clear_read", ADDR_IRQ_CLEAR, 32'h0);
        // Interrupt: raise, mask, unmask, clear
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h7);
        rdchk("status_clr", ADDR_IRQ_STATUS, 32'h0);
        cmd_step(8'h00, 8'h3C, 8'hFF, 8'h3C);
        rdchk("status_set", ADDR_IRQ_STATUS, 32'h3);
        repeat (2) @(negedge clk_in);
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h1);
        repeat (2) @(negedge clk_in);
        chk("irq_on", 32'h1, {31'h0, irq});
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h1);
        repeat (2) @(negedge clk_in);
        chk("irq_cleared", 32'h0, {31'h0, irq});
        rdchk("status_left", ADDR_IRQ_STATUS, 32'h2);
        // Status is read-only; a mismatching test raises the some-false event
        apb(1'b1, ADDR_IRQ_STATUS, 32'h0);
        cmd_step(8'h00, 8'h3C, 8'hFF, 8'hC3);
        rdchk("status_miss", ADDR_IRQ_STATUS, 32'h7);
        rdchk("enable_read", ADDR_IRQ_ENABLE, 32'h1);
        $display("test interrupt done");
        // Enable low: the pin synchroniser must not follow the new level
        ce      <= 1'b0;
        ext_lvl <= 8'h96;
        repeat (6) @(posedge clk_in);
        chk("irq_frozen", 32'h1, {31'h0, irq});
        ce <= 1'b1;
        rdchk("lvl_frozen", ADDR_BIT_IO_DIRECTION_AND_LEVEL, 32'h0000_003C);
        rdchk("lvl_thawed", ADDR_BIT_IO_DIRECTION_AND_LEVEL, 32'h0000_0096);
        $display("test enable done");
        final_report();
    end
endmodule // bit_io_port_with_test_flags_bench

`default_nettype wire
